// ==== include/txf_regs.vh ====
// Purpose: constants for the transmit FIFO block
// Assumes: 32-bit Avalon-MM register slave, byte addresses
// Notes:   threshold codes are scaled into 32-bit word counts
`ifndef TXF_REGS_VH
`define TXF_REGS_VH

`define TXF_AW          10
`define TXF_PW          11
`define TXF_DEPTH       11'h400
`define TXF_EW          34
`define TXF_EOF_BIT     32
`define TXF_VOID_BIT    33

`define TXF_CTRL_OFS    3'h0
`define TXF_THR_OFS     3'h1
`define TXF_STAT_OFS    3'h2
`define TXF_IRQ_OFS     3'h3
`define TXF_MASK_OFS    3'h4

`define TXF_CTRL_RST    32'h0000_0000
`define TXF_THR_RST     32'h0000_1F10
`define TXF_ASND_LSB    0
`define TXF_FLUSH_BIT   8
`define TXF_WM1_LSB     0
`define TXF_WM2_LSB     8
`define TXF_ASND_SHIFT  3
`define TXF_WM_SHIFT    5
`define TXF_IRQ_OVF     0
`define TXF_IRQ_UNF     1
`define TXF_IRQ_W       2

`endif

// ==== src/txf_fifo.v ====
// Purpose: 4 KB transmit FIFO, host write side to MAC read side
// Assumes: clock is the host clock, pcs_clock the MAC clock
// Notes:   one entry is 32 data bits plus end and void marks
//
// How it works
// (RULE1) The buffer holds 1024 words of 32 bits, which is 4 Kbytes.
// (RULE2) Writes run on the host clock, reads on the separate PCS clock.
// (RULE3) Draining starts on a stored end of frame or above AutoSend.
// (RULE4) AutoSend is six bits, each step eight words of the lower half.
// (RULE5) AutoSend code zero starts draining only when the buffer is full.
// (RULE6) Each level flag goes low above its threshold, high below it.
// (RULE7) Each level threshold is five bits, each step 32 words.
// (RULE8) Running dry mid-packet sends a void mark and drops the rest.
// (RULE9) A full buffer refuses host words until space frees up.
// (RULE10) On overflow the stored part ends in a void mark, rest dropped.
// (RULE11) With sync lost or negotiation open, nothing is sent to the MAC.
// (RULE12) With flush enabled and link down, leaving data is thrown away.
// (RULE13) Pointers cross clock domains Gray coded through two flops.
`timescale 1ns/1ps
`include "txf_regs.vh"

module txf_fifo (
  input  wire        clock,             // host clock
  input  wire        rst,               // async reset, active high
  input  wire [4:0]  avs_address,       // byte address
  input  wire        avs_read,          // read request
  input  wire        avs_write,         // write request
  input  wire [31:0] avs_writedata,     // write data
  input  wire [3:0]  avs_byteenable,    // write byte lanes
  output reg  [31:0] avs_readdata,      // read data
  output reg         avs_waitrequest,   // stall while high
  output reg         irq,               // level interrupt
  input  wire        host_valid,        // host word offered
  input  wire [31:0] host_data,         // host word
  input  wire        host_eof,          // last word of packet
  output reg         host_ready,        // word taken when high
  output reg         tx_level_flag_one_n, // low above level one
  output reg         tx_level_flag_two_n, // low above level two
  input  wire        pcs_clock,         // MAC side clock
  input  wire        rx_sync_pin,       // receiver in sync
  input  wire        an_done_pin,       // negotiation complete
  input  wire        mac_ready,         // MAC asks for a word
  output reg         tx_valid,          // word on tx_data
  output reg  [31:0] tx_data,           // word to MAC
  output reg         tx_eof,            // word ends the packet
  output reg         tx_void,           // send void code now
  output reg         tx_link_idle       // idle or config only
);

  reg [`TXF_EW-1:0] mem [0:`TXF_DEPTH-1]; // see (RULE1)

  function [`TXF_PW-1:0] bin2gray;
    input [`TXF_PW-1:0] b;
    begin
      bin2gray = b ^ (b >> 1);
    end
  endfunction

  function [`TXF_PW-1:0] gray2bin;
    input [`TXF_PW-1:0] g;
    integer i;
    begin
      gray2bin[`TXF_PW-1] = g[`TXF_PW-1];
      for (i = `TXF_PW - 2; i >= 0; i = i - 1) begin
        gray2bin[i] = gray2bin[i+1] ^ g[i];
      end
    end
  endfunction

  // Host clock domain
  reg  [31:0]        ctrl_reg;
  reg  [31:0]        thr_reg;
  reg  [31:0]        mask_reg;
  reg  [1:0]         ists_reg;
  reg  [`TXF_PW-1:0] wptr_reg;
  reg  [`TXF_PW-1:0] wgray_reg;
  reg  [`TXF_PW-1:0] weof_reg;
  reg  [`TXF_PW-1:0] weofg_reg;
  reg  [`TXF_PW-1:0] rg_s1_reg;
  reg  [`TXF_PW-1:0] rg_s2_reg;
  reg                wdrop_reg;
  reg                mark_reg;
  reg  [2:0]         unf_s_reg;
  reg  [1:0]         lnk_s_reg;
  // Read side state that the write side synchronises
  reg  [`TXF_PW-1:0] rd_gray_reg;
  reg                unf_tog_reg;
  reg                link_up_reg;

  wire [`TXF_PW-1:0] rptr_w = gray2bin(rg_s2_reg);
  wire [`TXF_PW-1:0] occ_w  = wptr_reg - rptr_w;
  wire               full_w = (occ_w == `TXF_DEPTH);
  wire               take   = host_valid && host_ready;
  wire               ovf_ev = host_valid && !host_ready && full_w &&
                              !wdrop_reg;
  wire               mark_wr = mark_reg && !full_w;
  wire               data_wr = take && !wdrop_reg;
  wire               do_wr   = mark_wr || data_wr;
  wire               eof_wr  = mark_wr || (data_wr && host_eof);
  wire [`TXF_PW-1:0] wptr_next = wptr_reg + {{(`TXF_PW-1){1'b0}}, do_wr};
  wire [`TXF_PW-1:0] occ_next  = wptr_next - rptr_w;
  wire               mark_next = ovf_ev || (mark_reg && !mark_wr);
  wire [`TXF_PW-1:0] weof_next = weof_reg + {{(`TXF_PW-1){1'b0}}, eof_wr};
  wire               unf_ev    = unf_s_reg[1] ^ unf_s_reg[2];

  always @(posedge clock) begin
    if (do_wr) begin
      // Marker carries both marks so the reader ends the frame on it
      mem[wptr_reg[`TXF_AW-1:0]] <= mark_wr ? {2'b11, 32'h0000_0000}
                                            : {1'b0, host_eof, host_data};
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wptr_reg   <= {`TXF_PW{1'b0}};
      wgray_reg  <= {`TXF_PW{1'b0}};
      weof_reg   <= {`TXF_PW{1'b0}};
      weofg_reg  <= {`TXF_PW{1'b0}};
      rg_s1_reg  <= {`TXF_PW{1'b0}};
      rg_s2_reg  <= {`TXF_PW{1'b0}};
      wdrop_reg  <= 1'b0;
      mark_reg   <= 1'b0;
      host_ready <= 1'b0;
      unf_s_reg  <= 3'h0;
      lnk_s_reg  <= 2'h0;
    end else begin
      wptr_reg   <= wptr_next;
      wgray_reg  <= bin2gray(wptr_next); // see (RULE13)
      weof_reg   <= weof_next;
      weofg_reg  <= bin2gray(weof_next);
      rg_s1_reg  <= rd_gray_reg;
      rg_s2_reg  <= rg_s1_reg;
      mark_reg   <= mark_next; // see (RULE10)
      if (ovf_ev) begin
        wdrop_reg <= 1'b1; // see (RULE10)
      end else if (take && wdrop_reg && host_eof) begin
        wdrop_reg <= 1'b0;
      end
      // Ready only while a slot is free; the read pointer seen is late,
      // so this errs toward refusing
      host_ready <= (occ_next < `TXF_DEPTH) && !mark_next; // see (RULE9)
      unf_s_reg  <= {unf_s_reg[1:0], unf_tog_reg};
      lnk_s_reg  <= {lnk_s_reg[0], link_up_reg};
    end
  end

  // Level flags, occupancy compared with code times 32 words
  wire [`TXF_PW-1:0] wm1_thr = {1'b0, thr_reg[`TXF_WM1_LSB +: 5], 5'h00};
  wire [`TXF_PW-1:0] wm2_thr = {1'b0, thr_reg[`TXF_WM2_LSB +: 5], 5'h00};

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_level_flag_one_n <= 1'b1;
      tx_level_flag_two_n <= 1'b1;
    end else begin
      if (occ_w > wm1_thr) begin
        tx_level_flag_one_n <= 1'b0; // see (RULE6) (RULE7)
      end else if (occ_w < wm1_thr) begin
        tx_level_flag_one_n <= 1'b1;
      end
      if (occ_w > wm2_thr) begin
        tx_level_flag_two_n <= 1'b0; // see (RULE6) (RULE7)
      end else if (occ_w < wm2_thr) begin
        tx_level_flag_two_n <= 1'b1;
      end
    end
  end

  // Register slave: one wait cycle, then a single answer cycle
  wire [2:0]  reg_idx = avs_address[4:2];
  wire [31:0] bmask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire        bus_req = (avs_read || avs_write) && avs_waitrequest;
  wire        wr_go   = avs_write && !avs_waitrequest;
  wire [1:0]  ev_set  = {unf_ev, ovf_ev};
  wire [1:0]  w1c     = (wr_go && reg_idx == `TXF_IRQ_OFS) ?
                        (avs_writedata[1:0] & bmask[1:0]) : 2'h0;
  wire [1:0]  ists_next = ev_set | (ists_reg & ~w1c);
  reg  [31:0] rd_mux;

  always @* begin
    case (reg_idx)
      `TXF_CTRL_OFS: rd_mux = ctrl_reg;
      `TXF_THR_OFS:  rd_mux = thr_reg;
      `TXF_STAT_OFS: rd_mux = {16'h0000, lnk_s_reg[1], wdrop_reg,
                               tx_level_flag_two_n, tx_level_flag_one_n,
                               1'b0, occ_w};
      `TXF_IRQ_OFS:  rd_mux = {30'h0, ists_reg};
      `TXF_MASK_OFS: rd_mux = mask_reg;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_reg        <= `TXF_CTRL_RST;
      thr_reg         <= `TXF_THR_RST;
      mask_reg        <= 32'h0000_0000;
      ists_reg        <= 2'h0;
      irq             <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !bus_req;
      if (bus_req && avs_read) begin
        avs_readdata <= rd_mux;
      end
      if (wr_go && reg_idx == `TXF_CTRL_OFS) begin
        ctrl_reg <= ((ctrl_reg & ~bmask) | (avs_writedata & bmask)) &
                    32'h0000_013F;
      end
      if (wr_go && reg_idx == `TXF_THR_OFS) begin
        thr_reg <= ((thr_reg & ~bmask) | (avs_writedata & bmask)) &
                   32'h0000_1F1F;
      end
      if (wr_go && reg_idx == `TXF_MASK_OFS) begin
        mask_reg <= ((mask_reg & ~bmask) | (avs_writedata & bmask)) &
                    32'h0000_0003;
      end
      ists_reg <= ists_next;
      irq      <= |(ists_next & mask_reg[1:0]);
    end
  end

  // PCS clock domain
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SEND = 3'b010;
  localparam [2:0] ST_DROP = 3'b100;

  reg  [2:0]         state_reg;
  reg  [`TXF_PW-1:0] rptr_reg;
  reg  [`TXF_PW-1:0] wg_s1_reg;
  reg  [`TXF_PW-1:0] wg_s2_reg;
  reg  [`TXF_PW-1:0] eg_s1_reg;
  reg  [`TXF_PW-1:0] eg_s2_reg;
  reg  [`TXF_PW-1:0] reof_reg;
  reg  [5:0]         asnd_s1_reg;
  reg  [5:0]         asnd_s2_reg;
  reg  [5:0]         asnd_reg;
  reg  [1:0]         fl_s_reg;
  reg  [2:0]         sync_s_reg;
  reg  [2:0]         an_s_reg;
  reg                sync_ok_reg;
  reg                an_ok_reg;

  wire [`TXF_PW-1:0] wptr_r   = gray2bin(wg_s2_reg);
  wire [`TXF_PW-1:0] occ_r    = wptr_r - rptr_reg;
  wire               empty_r  = (occ_r == {`TXF_PW{1'b0}});
  wire               eof_pend = (gray2bin(eg_s2_reg) != reof_reg);
  wire [`TXF_PW-1:0] asnd_thr = {2'b00, asnd_reg, 3'h0};
  wire               asnd_hit = (asnd_reg == 6'h00) ?
                                (occ_r == `TXF_DEPTH) :   // see (RULE5)
                                (occ_r > asnd_thr);       // see (RULE4)
  wire               start    = eof_pend || asnd_hit;      // see (RULE3)
  wire [`TXF_EW-1:0] head     = mem[rptr_reg[`TXF_AW-1:0]]; // see (RULE2)
  // Flush in any state, so a packet cut by link loss cannot wedge
  wire               flushing = !link_up_reg && fl_s_reg[1] &&
                                !empty_r;                 // see (RULE12)
  wire               send_pop = (state_reg == ST_SEND) && mac_ready &&
                                link_up_reg && !empty_r;  // see (RULE11)
  wire               pop      = send_pop || flushing ||
                                ((state_reg == ST_DROP) && !empty_r);
  wire [`TXF_PW-1:0] rptr_next = rptr_reg + {{(`TXF_PW-1){1'b0}}, pop};
  wire               eof_pop  = pop && head[`TXF_EOF_BIT];

  always @(posedge pcs_clock or posedge rst) begin
    if (rst) begin
      wg_s1_reg   <= {`TXF_PW{1'b0}};
      wg_s2_reg   <= {`TXF_PW{1'b0}};
      eg_s1_reg   <= {`TXF_PW{1'b0}};
      eg_s2_reg   <= {`TXF_PW{1'b0}};
      asnd_s1_reg <= 6'h00;
      asnd_s2_reg <= 6'h00;
      asnd_reg    <= 6'h00;
      fl_s_reg    <= 2'h0;
      sync_s_reg  <= 3'h0;
      an_s_reg    <= 3'h0;
      sync_ok_reg <= 1'b0;
      an_ok_reg   <= 1'b0;
      link_up_reg <= 1'b0;
    end else begin
      wg_s1_reg   <= wgray_reg; // see (RULE13)
      wg_s2_reg   <= wg_s1_reg;
      eg_s1_reg   <= weofg_reg;
      eg_s2_reg   <= eg_s1_reg;
      // Code taken only once two samples agree, so a write caught
      // mid-change never yields a mixed threshold
      asnd_s1_reg <= ctrl_reg[`TXF_ASND_LSB +: 6];
      asnd_s2_reg <= asnd_s1_reg;
      if (asnd_s1_reg == asnd_s2_reg) begin
        asnd_reg <= asnd_s2_reg;
      end
      fl_s_reg    <= {fl_s_reg[0], ctrl_reg[`TXF_FLUSH_BIT]};
      sync_s_reg  <= {sync_s_reg[1:0], rx_sync_pin};
      an_s_reg    <= {an_s_reg[1:0], an_done_pin};
      if (sync_s_reg[1] == sync_s_reg[2]) begin
        sync_ok_reg <= sync_s_reg[2];
      end
      if (an_s_reg[1] == an_s_reg[2]) begin
        an_ok_reg <= an_s_reg[2];
      end
      link_up_reg <= sync_ok_reg && an_ok_reg; // see (RULE11)
    end
  end

  always @(posedge pcs_clock or posedge rst) begin
    if (rst) begin
      state_reg    <= ST_IDLE;
      rptr_reg     <= {`TXF_PW{1'b0}};
      rd_gray_reg  <= {`TXF_PW{1'b0}};
      reof_reg     <= {`TXF_PW{1'b0}};
      unf_tog_reg  <= 1'b0;
      tx_valid     <= 1'b0;
      tx_data      <= 32'h0000_0000;
      tx_eof       <= 1'b0;
      tx_void      <= 1'b0;
      tx_link_idle <= 1'b1;
    end else begin
      rptr_reg     <= rptr_next;
      rd_gray_reg  <= bin2gray(rptr_next); // see (RULE13)
      reof_reg     <= reof_reg + {{(`TXF_PW-1){1'b0}}, eof_pop};
      tx_link_idle <= !link_up_reg; // see (RULE11)
      tx_valid     <= send_pop && !head[`TXF_VOID_BIT];
      tx_data      <= send_pop ? head[31:0] : 32'h0000_0000;
      tx_eof       <= send_pop && head[`TXF_EOF_BIT] &&
                      !head[`TXF_VOID_BIT];
      tx_void      <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (link_up_reg && start) begin
            state_reg <= ST_SEND; // see (RULE3) (RULE11)
          end
        end
        ST_SEND: begin
          if (send_pop && head[`TXF_VOID_BIT]) begin
            tx_void   <= 1'b1; // see (RULE10)
            state_reg <= ST_IDLE;
          end else if (eof_pop) begin
            state_reg <= ST_IDLE;
          end else if (link_up_reg && mac_ready && empty_r) begin
            tx_void     <= 1'b1; // see (RULE8)
            unf_tog_reg <= !unf_tog_reg;
            state_reg   <= ST_DROP;
          end
        end
        ST_DROP: begin
          // Late words of the broken packet are thrown away
          if (eof_pop) begin
            state_reg <= ST_IDLE; // see (RULE8)
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // txf_fifo

// ==== tb/txf_fifo_checker.sv ====
// Purpose: port checks for the transmit FIFO
// Assumes: host side on clock, MAC side on pcs_clock
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
module txf_fifo_checker (
  input logic clock, rst, avs_read, avs_write, avs_waitrequest,
  input logic pcs_clock, rx_sync_pin, an_done_pin, mac_ready,
  input logic tx_valid, tx_eof, tx_void, tx_link_idle
);
  a_bus_answer: assert property (@(posedge clock) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_wait_single: assert property (@(posedge clock) disable iff (rst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_word_req: assert property (@(posedge pcs_clock) disable iff (rst)
    tx_valid |-> $past(mac_ready))
    else $error("word sent without request");
  a_eof_word: assert property (@(posedge pcs_clock) disable iff (rst)
    tx_eof |-> tx_valid)
    else $error("end mark without word");
  a_void_alone: assert property (@(posedge pcs_clock) disable iff (rst)
    tx_void |-> !tx_valid ##1 !tx_void)
    else $error("void mark malformed");
  a_idle_hold: assert property (@(posedge pcs_clock) disable iff (rst)
    tx_link_idle |-> !tx_valid)
    else $error("word sent while link down");
  a_sync_lost: assert property (@(posedge pcs_clock) disable iff (rst)
    !rx_sync_pin [*8] |-> tx_link_idle)
    else $error("link not down on sync loss");
  a_an_open: assert property (@(posedge pcs_clock) disable iff (rst)
    !an_done_pin [*8] |-> tx_link_idle)
    else $error("link not down during negotiation");
  a_link_up: assert property (@(posedge pcs_clock) disable iff (rst)
    (rx_sync_pin && an_done_pin) [*8] |-> !tx_link_idle)
    else $error("link stays down");
endmodule // txf_fifo_checker

// ==== tb/txf_host_model.sv ====
// Purpose: host writer offering packet words
// Assumes: word taken at edge with valid and ready
// Notes:   holds each word until taken, so full buffer is pushed on
`timescale 1ns/1ps
module txf_host_model (
  input  logic        clock,      // host clock
  input  logic        rst,        // async reset
  input  logic        go,         // start a packet
  input  logic [10:0] len,        // words in packet
  input  logic        eof_en,     // mark last word
  input  logic        host_ready, // word taken
  output logic        host_valid, // word offered
  output logic [31:0] host_data,  // word
  output logic        host_eof,   // last word
  output logic        busy        // packet running
);
  logic [10:0] n;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      busy <= 0; host_valid <= 0; host_eof <= 0; n <= 0;
      host_data <= 32'h5A00_0000;
    end else if (go && !busy) begin
      busy <= 1; host_valid <= 1; n <= 1;
      host_eof <= eof_en && len == 1;
    end else if (host_valid && host_ready) begin
      if (n == len) begin
        // Released data shows a changed value, not the last word
        busy <= 0; host_valid <= 0; host_eof <= 0;
        host_data <= ~host_data;
      end else begin
        n <= n + 1; host_data <= host_data + 1;
        host_eof <= eof_en && n + 1 == len;
      end
    end
  end
endmodule // txf_host_model

// ==== tb/txf_fifo_tb.sv ====
// Purpose: self-checking bench for the transmit FIFO
// Assumes: registers reached over Avalon-MM, one cycle answer
// Notes:   MAC side drained by a monitor counting words and voids
`timescale 1ns/1ps
module txf_fifo_tb;
  logic clock = 0, pcs_clock = 0, rst = 1;
  logic [4:0] avs_address = 0;
  logic avs_read = 0, avs_write = 0, go = 0, eof_en = 0, mac_ready = 0;
  logic rx_sync_pin = 1, an_done_pin = 1, last_eof;
  logic [31:0] avs_writedata = 0, avs_readdata, host_data, tx_data;
  logic [31:0] first, rv;
  logic [10:0] len = 0;
  logic avs_waitrequest, irq, host_valid, host_eof, host_ready, busy;
  logic fl1_n, fl2_n, tx_valid, tx_eof, tx_void, tx_link_idle;
  int fail_count = 0, checks = 0, txn = 0, voids = 0;
  txf_fifo uut (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .host_valid(host_valid), .host_data(host_data),
    .host_eof(host_eof), .host_ready(host_ready),
    .tx_level_flag_one_n(fl1_n), .tx_level_flag_two_n(fl2_n),
    .pcs_clock(pcs_clock), .rx_sync_pin(rx_sync_pin),
    .an_done_pin(an_done_pin), .mac_ready(mac_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_eof(tx_eof),
    .tx_void(tx_void), .tx_link_idle(tx_link_idle));
  txf_host_model host (.clock(clock), .rst(rst), .go(go), .len(len),
    .eof_en(eof_en), .host_ready(host_ready), .host_valid(host_valid),
    .host_data(host_data), .host_eof(host_eof), .busy(busy));
  initial forever #20 clock = ~clock;
  initial forever #4 pcs_clock = ~pcs_clock;
  always @(posedge pcs_clock) begin
    if (tx_valid === 1'b1) begin
      if (txn == 0) first = tx_data;
      txn++;
      last_eof = tx_eof;
    end
    if (tx_void === 1'b1) voids++;
  end
  task chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a; avs_writedata <= d; avs_write <= 1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    avs_write <= 0;
  endtask
  task rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clock);
    avs_address <= a; avs_read <= 1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 0;
  endtask
  task send(input int n, input logic e);
    @(posedge clock);
    len <= n; eof_en <= e; go <= 1;
    @(posedge clock);
    go <= 0;
    @(posedge clock);
    while (busy === 1'b1) @(posedge clock);
    // Let pointers cross both ways before looking
    repeat (20) @(posedge clock);
  endtask
  task clr;
    txn = 0; voids = 0;
    wr(5'h0C, 32'h3);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #500000;
    fail_count++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge clock);
    rst <= 0;
    rd(5'h00, rv); chk("ctrl", rv, 32'h0);
    rd(5'h04, rv); chk("thr", rv, 32'h1F10);
    rd(5'h0C, rv); chk("irq reg", rv, 32'h0);
    rd(5'h14, rv); chk("unmapped", rv, 32'h0);
    chk("flags", {fl2_n, fl1_n}, 2'b11);
    $display("test reset done");
    mac_ready <= 1;
    send(4, 1);
    chk("eof count", txn, 4);
    chk("eof last", last_eof, 1);
    chk("first word", first, 32'h5A00_0000);
    $display("test eof done");
    wr(5'h00, 32'h1); clr; send(12, 0);
    chk("autosend", txn > 8, 1);
    chk("void", voids, 1);
    rd(5'h0C, rv); chk("underflow", rv, 32'h2);
    wr(5'h10, 32'h2); repeat (2) @(posedge clock);
    chk("irq on", irq, 1);
    wr(5'h0C, 32'h2); repeat (2) @(posedge clock);
    chk("irq off", irq, 0);
    rv = txn; send(1, 1);
    chk("dropped", txn, rv);
    $display("test underflow done");
    wr(5'h00, 32'h0); mac_ready <= 0; wr(5'h04, 32'h0201); clr;
    send(40, 0);
    chk("levels", {fl2_n, fl1_n}, 2'b10);
    rd(5'h08, rv); chk("occupancy", rv[10:0], 11'd40);
    chk("held", txn, 0);
    $display("test levels done");
    mac_ready <= 1; send(990, 1); repeat (300) @(posedge clock);
    chk("ovf words", txn, 1024);
    chk("ovf void", voids, 1);
    rd(5'h0C, rv); chk("overflow", rv, 32'h1);
    chk("levels back", {fl2_n, fl1_n}, 2'b11);
    $display("test overflow done");
    clr; an_done_pin <= 0; repeat (10) @(posedge clock);
    chk("an idle", tx_link_idle, 1);
    an_done_pin <= 1; rx_sync_pin <= 0; send(5, 1);
    chk("idle", tx_link_idle, 1);
    chk("no drain", txn, 0);
    rd(5'h08, rv); chk("kept", {rv[15], rv[10:0]}, 12'd5);
    wr(5'h00, 32'h100); repeat (20) @(posedge clock);
    rd(5'h08, rv); chk("flushed", rv[10:0], 11'd0);
    chk("flush silent", txn, 0);
    $display("test link down done");
    final_report;
  end
endmodule // txf_fifo_tb
bind txf_fifo txf_fifo_checker u_chk (.clock, .rst, .avs_read, .avs_write,
  .avs_waitrequest, .pcs_clock, .rx_sync_pin, .an_done_pin, .mac_ready,
  .tx_valid, .tx_eof, .tx_void, .tx_link_idle);
